// [rtl/ctxdec_regs.svh]
// Offsets, field positions, reset values and timing counts for the decoder
`ifndef CTXDEC_REGS_SVH
`define CTXDEC_REGS_SVH

// Register byte offsets
`define CTXDEC_ADDR_CTRL      8'h00
`define CTXDEC_ADDR_STATUS    8'h04
`define CTXDEC_ADDR_ERR_CLR   8'h08
`define CTXDEC_ADDR_DESC0     8'h10

// Number of descriptor words held, 256 bits
`define CTXDEC_DESC_WORDS     8

// Descriptor field positions
`define CTXDEC_FTB_HI         115
`define CTXDEC_FTB_LO         68
`define CTXDEC_FTB_V30_LO     112
`define CTXDEC_HWU_LO         124
`define CTXDEC_HWU_HI         127
`define CTXDEC_NS1_BIT        128
`define CTXDEC_SECOND_REGION_HIER_ATTR_OFF_BIT       129
`define CTXDEC_STB_HI         179
`define CTXDEC_STB_LO         132
`define CTXDEC_NS0_BIT        64
`define CTXDEC_FIRST_REGION_HIER_ATTR_OFF_BIT       65

// Control register fields
`define CTXDEC_CTRL_GO        0
`define CTXDEC_CTRL_WALKOFF   1
`define CTXDEC_CTRL_GRAN_LO   2
`define CTXDEC_CTRL_SIZE_LO   4
`define CTXDEC_CTRL_REGIME_LO 8
`define CTXDEC_CTRL_SECURE    11
`define CTXDEC_CTRL_V30       12
`define CTXDEC_CTRL_HAD       13
`define CTXDEC_CTRL_PAGE_HW_ATTR_SUPPORT      14
`define CTXDEC_CTRL_ALIGN_LO  16

// Reset values
`define CTXDEC_CTRL_RESET     32'h0000_0000
`define CTXDEC_STATUS_RESET   32'h0000_0000

// Latency of one decode, in cycles
`define CTXDEC_DECODE_CYCLES  1

`endif

// [rtl/ctxdec_pkg.sv]
// Types shared by the context descriptor decoder
package ctxdec_pkg;

   typedef enum logic [1:0]
   {
      CTXDEC_G4K  = 2'b00,
      CTXDEC_G64K = 2'b01,
      CTXDEC_G16K = 2'b10
   } ctxdec_gran_t;

   typedef enum logic [2:0]
   {
      CTXDEC_OS32 = 3'b000,
      CTXDEC_OS36 = 3'b001,
      CTXDEC_OS40 = 3'b010,
      CTXDEC_OS42 = 3'b011,
      CTXDEC_OS44 = 3'b100,
      CTXDEC_OS48 = 3'b101,
      CTXDEC_OS52 = 3'b110
   } ctxdec_osize_t;

   // Regime: codes 3'b100 and above stand for EL2 without E2H or EL3; EL2 with E2H is 3'b010
   typedef enum logic [2:0]
   {
      CTXDEC_NS_EL1  = 3'b000,
      CTXDEC_SEC_EL1 = 3'b001,
      CTXDEC_EL2_E2H = 3'b010,
      CTXDEC_EL2     = 3'b100,
      CTXDEC_EL3     = 3'b101
   } ctxdec_regime_t;

   typedef enum logic [1:0]
   {
      CTXDEC_IDLE   = 2'b00,
      CTXDEC_DECODE = 2'b01,
      CTXDEC_DONE   = 2'b10
   } ctxdec_state_t;

endpackage : ctxdec_pkg

// [rtl/ctxdec_top.sv]
// Context descriptor table base decoder with AXI4-Lite registers
// What this block does
// - Bits 115:68 give first base address 51:4
// - Clear base bits below table alignment
// - 64KB granule, 52-bit output: clear bits 5:0
// - First walk disabled: ignore base, no checks
// - Illegal if first base exceeds output size
// - Illegal above 48 bits with small granule
// - Earliest version: bits 115:112 reserved zero
// - Bit 124 gives bit 59 hardware use
// - Ignore use bits without support or disable
// - Bits 125-127 govern bits 60 to 62
// - Earliest version: use bits reserved zero
// - Bit 128 second fetch attribute, EL2/EL3 zero
// - Bit 129 disables second hierarchical attributes
// - EL2/EL3: second disable bit reserved zero
// - Bits 179:132 give second base 51:4
// - Fetch attribute 0 secure, 1 non-secure
// - Fetch attributes used only for secure entries
// - No feature: ignore both disable bits
// - Disabled region ignores table permission bits
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "ctxdec_regs.svh"
module ctxdec_top
(
   input  wire logic                    clock,
   input  wire logic                    rst,
   input  wire logic [7:0]              s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [7:0]              s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   output logic [51:0]                  first_table_base,
   output logic [51:0]                  second_table_base,
   output logic                         first_table_nonsecure_fetch,
   output logic                         second_table_nonsecure_fetch,
   output logic                         first_region_hier_attr_off,
   output logic                         second_region_hier_attr_off,
   output logic [3:0]                   hw_use_first,
   output logic                         decode_valid,
   output logic                         config_error
);
   import ctxdec_pkg::*;

   logic [31:0]     desc [`CTXDEC_DESC_WORDS];
   logic [255:0]    cd;
   logic [31:0]     ctrl;
   logic            err_sticky;
   logic            busy;
   ctxdec_state_t   state;
   logic            aw_held;
   logic            w_held;
   logic [7:0]      aw_addr;
   logic [31:0]     w_data;
   logic [3:0]      w_strb;
   logic            do_write;
   logic            err_clr;
   logic            go;
   logic            wr_ok;
   logic            rd_ok;
   logic [31:0]     rd_val;
   logic            walk_off;
   ctxdec_gran_t    gran;
   ctxdec_osize_t   osize;
   logic [2:0]      regime;
   logic            high_regime;
   logic            secure_entry;
   logic            ver30;
   logic            had_sup;
   logic            page_hw_attr_support_sup;
   logic [3:0]      align_bits;
   logic [51:0]     next_first_base;
   logic [51:0]     next_second_base;
   logic [51:0]     raw_first;
   logic [51:0]     align_mask;
   logic [5:0]      osize_bits;
   logic            next_illegal;
   logic            next_first_region_hier_attr_off;
   logic            next_second_region_hier_attr_off;
   genvar gi;
   generate
      for (gi = 0; gi < `CTXDEC_DESC_WORDS; gi++)
      begin : g_cd
         assign cd[gi*32 +: 32] = desc[gi];
      end
   endgenerate

   assign walk_off     = ctrl[`CTXDEC_CTRL_WALKOFF];
   assign gran         = ctxdec_gran_t'(ctrl[`CTXDEC_CTRL_GRAN_LO +: 2]);
   assign osize        = ctxdec_osize_t'(ctrl[`CTXDEC_CTRL_SIZE_LO +: 3]);
   assign regime       = ctrl[`CTXDEC_CTRL_REGIME_LO +: 3];
   assign high_regime  = regime[2];
   assign secure_entry = ctrl[`CTXDEC_CTRL_SECURE];
   assign ver30        = ctrl[`CTXDEC_CTRL_V30];
   assign had_sup      = ctrl[`CTXDEC_CTRL_HAD];
   assign page_hw_attr_support_sup     = ctrl[`CTXDEC_CTRL_PAGE_HW_ATTR_SUPPORT];
   assign align_bits   = ctrl[`CTXDEC_CTRL_ALIGN_LO +: 4];

   // AXI write path: address and data taken in either order
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;
   assign wr_ok         = (aw_addr[1:0] == 2'b00) &&
                          (aw_addr <= `CTXDEC_ADDR_DESC0 + 8'h1C) &&
                          (aw_addr != `CTXDEC_ADDR_STATUS) &&
                          (aw_addr != 8'h0C);
   assign err_clr       = do_write && (aw_addr == `CTXDEC_ADDR_ERR_CLR) &&
                          w_strb[0] && w_data[0];
   assign go            = do_write && (aw_addr == `CTXDEC_ADDR_CTRL) &&
                          w_strb[0] && w_data[`CTXDEC_CTRL_GO] && !busy;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
         aw_held <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end
      else if (do_write)
         w_held <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Control and descriptor words, byte lanes honoured; GO self-clears
   always_ff @(posedge clock)
   begin
      if (rst)
         ctrl <= `CTXDEC_CTRL_RESET;
      else
      begin
         if (do_write && aw_addr == `CTXDEC_ADDR_CTRL)
         begin
            for (int b = 0; b < 4; b++)
               if (w_strb[b])
                  ctrl[b*8 +: 8] <= w_data[b*8 +: 8];
         end
         ctrl[`CTXDEC_CTRL_GO] <= 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         for (int i = 0; i < `CTXDEC_DESC_WORDS; i++)
            desc[i] <= 32'h0000_0000;
      end
      else if (do_write && aw_addr >= `CTXDEC_ADDR_DESC0 && wr_ok && !busy)
      begin
         for (int b = 0; b < 4; b++)
            if (w_strb[b])
               desc[3'((aw_addr - `CTXDEC_ADDR_DESC0) >> 2)][b*8 +: 8] <=
                  w_data[b*8 +: 8];
      end
   end

   always_comb
   begin
      raw_first = {cd[`CTXDEC_FTB_HI:`CTXDEC_FTB_LO], 4'h0};
      if (ver30)
         raw_first[51:48] = 4'h0;
      case (osize)
         CTXDEC_OS32: osize_bits = 6'd32;
         CTXDEC_OS36: osize_bits = 6'd36;
         CTXDEC_OS40: osize_bits = 6'd40;
         CTXDEC_OS42: osize_bits = 6'd42;
         CTXDEC_OS44: osize_bits = 6'd44;
         CTXDEC_OS48: osize_bits = 6'd48;
         CTXDEC_OS52: osize_bits = 6'd52;
         default:     osize_bits = 6'd48;
      endcase
      align_mask = ~52'h0 << align_bits;
      if (gran == CTXDEC_G64K && osize == CTXDEC_OS52)
         align_mask[5:0] = 6'h00;
      next_first_base  = raw_first & align_mask;
      next_second_base = {cd[`CTXDEC_STB_HI:`CTXDEC_STB_LO], 4'h0};
      next_illegal = 1'b0;
      if (!walk_off)
      begin
         if ((raw_first >> osize_bits) != 52'h0)
            next_illegal = 1'b1;
         if (gran != CTXDEC_G64K && raw_first[51:48] != 4'h0)
            next_illegal = 1'b1;
      end
      // Disable bits count only with the feature present
      next_first_region_hier_attr_off = had_sup && cd[`CTXDEC_FIRST_REGION_HIER_ATTR_OFF_BIT];
      next_second_region_hier_attr_off = had_sup && !high_regime &&
                  cd[`CTXDEC_SECOND_REGION_HIER_ATTR_OFF_BIT];
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         state <= CTXDEC_IDLE;
      else
         case (state)
            CTXDEC_IDLE:   state <= go ? CTXDEC_DECODE : CTXDEC_IDLE;
            CTXDEC_DECODE: state <= CTXDEC_DONE;
            CTXDEC_DONE:   state <= go ? CTXDEC_DECODE : CTXDEC_DONE;
            default:       state <= CTXDEC_IDLE;
         endcase
   end
   assign busy = (state == CTXDEC_DECODE);

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         first_table_base             <= 52'h0;
         second_table_base            <= 52'h0;
         first_table_nonsecure_fetch  <= 1'b0;
         second_table_nonsecure_fetch <= 1'b0;
         first_region_hier_attr_off   <= 1'b0;
         second_region_hier_attr_off  <= 1'b0;
         hw_use_first                 <= 4'h0;
         decode_valid                 <= 1'b0;
      end
      else if (busy)
      begin
         // Illegal descriptor yields no usable translation
         decode_valid <= !next_illegal;
         first_table_base <= (walk_off || next_illegal) ?
                             52'h0 : next_first_base;
         second_table_base <= next_second_base;
         // Attributes: 1 means non-secure fetch, secure entries only
         first_table_nonsecure_fetch <= secure_entry &&
                                        cd[`CTXDEC_NS0_BIT];
         second_table_nonsecure_fetch <= secure_entry && !high_regime &&
                                 cd[`CTXDEC_NS1_BIT];
         // Flags tell the walker to drop table permission bits
         first_region_hier_attr_off  <= next_first_region_hier_attr_off;
         second_region_hier_attr_off <= next_second_region_hier_attr_off;
         hw_use_first <= (page_hw_attr_support_sup && next_first_region_hier_attr_off && !ver30) ?
                         cd[`CTXDEC_HWU_HI:`CTXDEC_HWU_LO] :
                         4'h0;
      end
      else if (go)
         decode_valid <= 1'b0;
   end

   // Sticky configuration error, set wins over clear
   always_ff @(posedge clock)
   begin
      if (rst)
         err_sticky <= 1'b0;
      else if (busy && next_illegal)
         err_sticky <= 1'b1;
      else if (err_clr)
         err_sticky <= 1'b0;
   end
   assign config_error = err_sticky;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_ok = (s_axi_araddr[1:0] == 2'b00) &&
                  (s_axi_araddr <= `CTXDEC_ADDR_DESC0 + 8'h1C) &&
                  (s_axi_araddr != 8'h0C);
   always_comb
   begin
      rd_val = 32'h0000_0000;
      if (s_axi_araddr == `CTXDEC_ADDR_CTRL)
         rd_val = ctrl;
      else if (s_axi_araddr == `CTXDEC_ADDR_STATUS)
         rd_val = {28'h0, busy, decode_valid, err_sticky, 1'b0};
      else if (s_axi_araddr >= `CTXDEC_ADDR_DESC0 && rd_ok)
         rd_val = desc[3'((s_axi_araddr - `CTXDEC_ADDR_DESC0) >> 2)];
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_ok ? rd_val : 32'h0000_0000;
         s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule : ctxdec_top
`default_nettype wire

// [sim/ctxdec_props.sv]
// Port-level properties of the context descriptor decoder
`timescale 1ns/10ps
`default_nettype none
module ctxdec_props
(
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [51:0] first_table_base,
   input wire logic [51:0] second_table_base,
   input wire logic        first_region_hier_attr_off,
   input wire logic [3:0]  hw_use_first,
   input wire logic        decode_valid,
   input wire logic        config_error
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata not held");
   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready
      && !s_axi_wready) else $error("write taken during response");
   rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during response");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_rresp[0]) else $error("read answer late");
   first_low_a: assert property (first_table_base[3:0] == 4'h0)
      else $error("first base low bits set");
   second_low_a: assert property (second_table_base[3:0] == 4'h0)
      else $error("second base low bits set");
   hwu_gate_a: assert property (hw_use_first != 4'h0 |->
      first_region_hier_attr_off) else $error("use bits not gated");
   err_stop_a: assert property ($rose(config_error) |->
      first_table_base == 52'h0 && !decode_valid) else $error("not stopped");
   err_hold_a: assert property ($fell(config_error) |-> s_axi_bvalid)
      else $error("error cleared without write");
endmodule : ctxdec_props
`default_nettype wire

// [sim/ctxdec_desc_mem.sv]
// Descriptor memory image the bench fetches words from
`timescale 1ns/10ps
`default_nettype none
module ctxdec_desc_mem
(
   input  wire logic         clock,
   input  wire logic         load,
   input  wire logic [255:0] fill,
   output logic      [31:0]  word [8]
);
   always_ff @(posedge clock)
   begin
      if (load)
      begin
         for (int i = 0; i < 8; i++)
            word[i] <= fill[32*i +: 32];
      end
   end
endmodule : ctxdec_desc_mem
`default_nettype wire

// [sim/test_ctx_desc_table_base_decode.sv]
// Self-checking bench for the context descriptor decoder
`timescale 1ns/10ps
`default_nettype none
`include "ctxdec_regs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module test_ctx_desc_table_base_decode;
   logic        clock = 0, rst = 1, mem_load = 0;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0]  s_axi_wstrb = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, decode_valid, config_error;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, ctl, rd;
   logic [51:0] first_table_base, second_table_base, raw, al;
   logic        first_table_nonsecure_fetch, second_table_nonsecure_fetch;
   logic        first_region_hier_attr_off, second_region_hier_attr_off;
   logic [3:0]  hw_use_first;
   logic [255:0] d;
   logic [31:0] mem_word [8];
   logic        ill, err, low;
   logic [3:0]  hwu;
   int          osb [8] = '{32, 36, 40, 42, 44, 48, 52, 48};
   int          seed = 32'hCBF0;
   int          cycles, failures, check_count;
   ctxdec_top i_dut (.*);
   ctxdec_desc_mem i_mem (.clock, .load(mem_load), .fill(d), .word(mem_word));
   task automatic final_report();
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                         input logic [1:0] er);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever
      begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            `CHK(s_axi_bresp, er)
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever
      begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            rd = s_axi_rdata;
            `CHK(s_axi_rresp, er)
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask : axi_rd
   initial
   begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         failures++;
         final_report();
      end
   end
   initial
   begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      axi_rd(`CTXDEC_ADDR_CTRL, 2'b00);
      `CHK(rd, `CTXDEC_CTRL_RESET)
      axi_rd(`CTXDEC_ADDR_STATUS, 2'b00);
      `CHK(rd, `CTXDEC_STATUS_RESET)
      axi_rd(8'h0C, 2'b10);
      `CHK(rd, 32'h0)
      axi_wr(`CTXDEC_ADDR_STATUS, 32'h0, 2'b10);
      err = 1'b0;
      for (int n = 0; n < 200; n++)
      begin
         for (int i = 0; i < 8; i++)
            d[32*i +: 32] = $random(seed);
         d[115:68] = d[115:68] >> ($unsigned($random(seed)) % 49);
         ctl = $random(seed) & 32'h000F_7FFE;
         if (ctl[3:2] == 2'b11) ctl[3] = 1'b0;
         mem_load <= 1'b1;
         @(posedge clock);
         mem_load <= 1'b0;
         @(posedge clock);
         for (int i = 0; i < 8; i++)
            axi_wr(`CTXDEC_ADDR_DESC0 + 8'(4 * i), mem_word[i], 2'b00);
         axi_wr(`CTXDEC_ADDR_CTRL, ctl | 32'h1, 2'b00);
         axi_rd(`CTXDEC_ADDR_STATUS, 2'b00);
         raw = {d[115:68], 4'h0};
         if (ctl[12]) raw[51:48] = 4'h0;
         ill = !ctl[1] && ((raw >> osb[ctl[6:4]]) != 0 ||
               (ctl[3:2] != 2'b01 && raw[51:48] != 4'h0));
         al = raw & ~((52'h1 << ctl[19:16]) - 52'h1);
         if (ctl[3:2] == 2'b01 && ctl[6:4] == 3'h6) al[5:0] = 6'h0;
         err = err | ill;
         low = !ctl[10];
         hwu = (ctl[14] && ctl[13] && d[65] && !ctl[12]) ? d[127:124] : 4'h0;
         `CHK(first_table_base, (ctl[1] || ill) ? 52'h0 : al)
         `CHK(decode_valid, !ill)
         `CHK(config_error, err)
         `CHK(rd[3:1], {1'b0, !ill, err})
         `CHK(second_table_base, {d[179:132], 4'h0})
         `CHK(first_table_nonsecure_fetch, ctl[11] & d[64])
         `CHK(second_table_nonsecure_fetch, ctl[11] & low & d[128])
         `CHK(first_region_hier_attr_off, ctl[13] & d[65])
         `CHK(second_region_hier_attr_off, ctl[13] & low & d[129])
         `CHK(hw_use_first, hwu)
         if (n % 4 == 3)
         begin
            axi_wr(`CTXDEC_ADDR_ERR_CLR, 32'h1, 2'b00);
            axi_rd(`CTXDEC_ADDR_STATUS, 2'b00);
            err = 1'b0;
            `CHK(rd[1], 1'b0)
         end
      end
      final_report();
   end
endmodule : test_ctx_desc_table_base_decode
bind ctxdec_top ctxdec_props i_props (.*);
`default_nettype wire
